// File: hw/opc_pkg.sv
// constants, states and carrier types of the overcurrent protection control
package opc_pkg;
    localparam int          NSW          = 4;
    localparam int          LIM_W        = 3;
    localparam logic [2:0]  LIM_HI_DEF   = 3'h4;
    localparam logic [2:0]  LIM_LO_DEF   = 3'h3;
    localparam logic [2:0]  LIM_HI_MAX   = 3'h4;
    localparam logic [2:0]  LIM_LO_MAX   = 3'h3;
    localparam int          HI_PAIR      = 2;
    localparam logic [8:0]  HIT_MAX      = 9'h100;
    localparam logic [8:0]  LS_LAST      = 9'h0ff;
    localparam logic [2:0]  CLEAN_LAST   = 3'h5;
    localparam int          CLK_MHZ      = 100;
    localparam int          OFF_TIME_US  = 20000;
    localparam int          DISCH_TIME_US = 1100;
    localparam int          OFF_CYCLES   = OFF_TIME_US * CLK_MHZ;
    localparam int          DISCH_CYCLES = DISCH_TIME_US * CLK_MHZ;
    localparam int          STORE_AW     = 2;
    localparam logic [2:0]  LOAD_END     = 3'h4;

    typedef enum logic [2:0] {
        ST_WAIT    = 3'h0,
        ST_RUN     = 3'h1,
        ST_LS_ON   = 3'h2,
        ST_LS_HOLD = 3'h3,
        ST_CUT     = 3'h4,
        ST_SKIP    = 3'h5,
        ST_DISCH   = 3'h6,
        ST_OFF     = 3'h7
    } opc_state_t;

    typedef enum logic [1:0] {
        NV_LOAD  = 2'h0,
        NV_IDLE  = 2'h1,
        NV_STORE = 2'h2
    } opc_nv_t;

    typedef struct packed {
        logic hs_gate;
        logic ls_gate;
    } opc_gate_t;

    typedef struct packed {
        logic comp_clamp;
        logic ea_tristate;
        logic comp_pull_low;
        logic ss_discharge;
        logic precharge;
        logic soft_start_go;
        logic ss_value_reset;
        logic shut_down;
    } opc_prot_t;

    typedef struct packed {
        logic                  we;
        logic [1:0]            sel;
        logic [LIM_W-1:0]      code;
    } opc_cfg_t;
endpackage : opc_pkg

// File: hw/opc_store.sv
// nonvolatile default store for the limit settings, registered read
module opc_store #(
    parameter int W     = 3,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic          sys_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    import opc_pkg::*;

    typedef logic [W-1:0] opc_image_t [DEPTH];

    // factory image; contents survive rst like the real store
    function automatic opc_image_t factory_image();
        for (int k = 0; k < DEPTH; k++) begin
            factory_image[k] = (k < HI_PAIR) ? W'(LIM_HI_DEF) : W'(LIM_LO_DEF);
        end
    endfunction : factory_image

    // initialiser, not a second process, so the clocked write stays the only driver
    opc_image_t mem = factory_image();

    initial begin
        if (DEPTH > (1 << AW) || W < LIM_W) begin
            $error("opc_store: bad geometry");
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : opc_store

// File: hw/opc_top.sv
// overcurrent protection control for four buck switchers
module opc_top
    import opc_pkg::*;
#(
    parameter int OFF_CNT   = OFF_CYCLES,
    parameter int DISCH_CNT = DISCH_CYCLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 cycle_tick,
    input  wire logic [NSW-1:0]       cur_over,
    input  wire logic [NSW-1:0]       pwm_end,
    input  wire logic [NSW-1:0]       soft_start_active,
    input  wire logic [1:0]           share_pair,
    input  wire logic                 digital_soft_start,
    input  wire opc_pkg::opc_cfg_t    cfg,
    input  wire logic                 store_cmd,
    output opc_pkg::opc_gate_t        gate [NSW],
    output opc_pkg::opc_prot_t        prot [NSW],
    output logic [LIM_W-1:0]          peak_current_limit [NSW],
    output logic                      load_done,
    output logic                      store_busy
);
    import opc_pkg::*;

    localparam int TW = $clog2(OFF_CNT + 1);
    localparam int PW = 3 * NSW + 3;

    initial begin
        if (DISCH_CNT < 1 || OFF_CNT <= DISCH_CNT) begin
            $error("opc_top: off time must exceed discharge time");
        end
    end

    // two-flop synchroniser for all analog comparator and strap pins
    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {digital_soft_start, share_pair, soft_start_active, pwm_end, cur_over};
            pin_sync <= pin_meta;
        end
    end

    logic [NSW-1:0] over_s;
    logic [NSW-1:0] end_s;
    logic [NSW-1:0] ss_s;
    logic [1:0]     share_s;
    logic           dss_s;

    assign over_s  = pin_sync[NSW-1:0];
    assign end_s   = pin_sync[2*NSW-1:NSW];
    assign ss_s    = pin_sync[3*NSW-1:2*NSW];
    assign share_s = pin_sync[3*NSW+1:3*NSW];
    assign dss_s   = pin_sync[3*NSW+2];

    // legal limit codes differ between the two switcher pairs
    function automatic logic code_ok(input logic [1:0] sel, input logic [LIM_W-1:0] code);
        code_ok = (int'(sel) < HI_PAIR) ? (code <= LIM_HI_MAX) : (code <= LIM_LO_MAX);
    endfunction : code_ok

    // settings load, host writes and store copy
    opc_nv_t             nv_st;
    logic [2:0]          nv_idx;
    logic                nv_ready;
    logic                st_wr;
    logic [STORE_AW-1:0] st_addr;
    logic [LIM_W-1:0]    st_wdata;
    logic [LIM_W-1:0]    st_rdata;
    logic [1:0]          ld_sel;

    assign ld_sel   = 2'(nv_idx - 3'h1);
    assign st_wr    = (nv_st == NV_STORE);
    assign st_addr  = nv_idx[STORE_AW-1:0];
    assign st_wdata = peak_current_limit[nv_idx[1:0]];

    opc_store #(
        .W     (LIM_W),
        .DEPTH (NSW),
        .AW    (STORE_AW)
    ) u_store (
        .sys_clk (sys_clk),
        .wr_en   (st_wr),
        .wr_addr (st_addr),
        .wr_data (st_wdata),
        .rd_addr (st_addr),
        .rd_data (st_rdata)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nv_st      <= NV_LOAD;
            nv_idx     <= '0;
            nv_ready   <= 1'b0;
            load_done  <= 1'b0;
            store_busy <= 1'b0;
            for (int k = 0; k < NSW; k++) begin
                peak_current_limit[k] <= (k < HI_PAIR) ? LIM_HI_DEF : LIM_LO_DEF;
            end
        end else begin
            unique case (nv_st)
                NV_LOAD: begin
                    // read data lags the address by one cycle
                    if (nv_idx != 3'h0) begin
                        if (code_ok(ld_sel, st_rdata)) begin
                            peak_current_limit[ld_sel] <= st_rdata;
                        end
                    end
                    if (nv_idx == LOAD_END) begin
                        nv_st     <= NV_IDLE;
                        nv_idx    <= '0;
                        nv_ready  <= 1'b1;
                        load_done <= 1'b1;
                    end else begin
                        nv_idx <= nv_idx + 3'h1;
                    end
                end
                NV_IDLE: begin
                    if (store_cmd) begin
                        nv_st      <= NV_STORE;
                        nv_idx     <= '0;
                        store_busy <= 1'b1;
                    end else if (cfg.we && code_ok(cfg.sel, cfg.code)) begin
                        peak_current_limit[cfg.sel] <= cfg.code;
                    end
                end
                NV_STORE: begin
                    // host writes are ignored while the copy runs
                    if (nv_idx == LOAD_END - 3'h1) begin
                        nv_st      <= NV_IDLE;
                        nv_idx     <= '0;
                        store_busy <= 1'b0;
                    end else begin
                        nv_idx <= nv_idx + 3'h1;
                    end
                end
                default: begin
                    nv_st <= NV_IDLE;
                end
            endcase
        end
    end

    logic [NSW-1:0] shut_now;

    for (genvar i = 0; i < NSW; i++) begin : g_sw
        localparam int P = i ^ 1;

        opc_state_t    st;
        logic [8:0]    hs_cnt;
        logic [8:0]    ls_cnt;
        logic [2:0]    clean;
        logic          ls_evt;
        logic [TW-1:0] timer;
        logic          det;
        logic          hit;
        logic          ls_hit;
        logic          pair_shut;
        logic          shared;
        logic          evt;

        assign shared    = share_s[i/2];
        assign det       = nv_ready & ~ss_s[i];
        assign hit       = det & over_s[i] & (st == ST_RUN);
        assign ls_hit    = det & over_s[i] & (st == ST_LS_ON);
        assign shut_now[i] = (hit && hs_cnt == HIT_MAX) || (ls_hit && ls_cnt == LS_LAST);
        assign pair_shut = shut_now[i] | (shared & shut_now[P]);
        assign evt       = (st == ST_CUT) || (st == ST_SKIP) || (st == ST_LS_HOLD);

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                st      <= ST_WAIT;
                timer   <= '0;
                gate[i] <= '0;
                prot[i] <= '0;
            end else begin
                prot[i].precharge      <= 1'b0;
                prot[i].soft_start_go  <= 1'b0;
                prot[i].ss_value_reset <= 1'b0;
                prot[i].comp_clamp     <= evt & ~shared;
                prot[i].ea_tristate    <= evt & shared;
                if (!nv_ready) begin
                    st      <= ST_WAIT;
                    gate[i] <= '0;
                end else if (pair_shut && st != ST_DISCH && st != ST_OFF) begin
                    st                     <= ST_DISCH;
                    timer                  <= '0;
                    gate[i]                <= '0;
                    prot[i].comp_pull_low  <= 1'b1;
                    prot[i].ss_discharge   <= 1'b1;
                    prot[i].ss_value_reset <= dss_s;
                    prot[i].shut_down      <= 1'b1;
                    prot[i].comp_clamp     <= 1'b0;
                    prot[i].ea_tristate    <= 1'b0;
                end else begin
                    unique case (st)
                        ST_WAIT: begin
                            if (cycle_tick) begin
                                st      <= ST_RUN;
                                gate[i] <= '{hs_gate: 1'b1, ls_gate: 1'b0};
                            end
                        end
                        ST_RUN: begin
                            if (hit) begin
                                st      <= ST_CUT;
                                gate[i] <= '0;
                            end else if (!cycle_tick && end_s[i]) begin
                                st      <= ST_LS_ON;
                                gate[i] <= '{hs_gate: 1'b0, ls_gate: 1'b1};
                            end
                        end
                        ST_LS_ON: begin
                            if (ls_hit) begin
                                st <= ST_LS_HOLD;
                            end else if (cycle_tick) begin
                                st      <= ST_RUN;
                                gate[i] <= '{hs_gate: 1'b1, ls_gate: 1'b0};
                            end
                        end
                        ST_LS_HOLD: begin
                            // low side stays on until a tick finds the current below limit
                            if (cycle_tick && !over_s[i]) begin
                                st      <= ST_RUN;
                                gate[i] <= '{hs_gate: 1'b1, ls_gate: 1'b0};
                            end
                        end
                        ST_CUT: begin
                            if (cycle_tick) begin
                                st <= ST_SKIP;
                            end
                        end
                        ST_SKIP: begin
                            if (cycle_tick && !over_s[i]) begin
                                st      <= ST_RUN;
                                gate[i] <= '{hs_gate: 1'b1, ls_gate: 1'b0};
                            end
                        end
                        ST_DISCH: begin
                            timer <= timer + 1'b1;
                            if (timer == TW'(DISCH_CNT - 1)) begin
                                st                    <= ST_OFF;
                                prot[i].comp_pull_low <= 1'b0;
                                prot[i].ss_discharge  <= 1'b0;
                            end
                        end
                        ST_OFF: begin
                            timer <= timer + 1'b1;
                            if (timer == TW'(OFF_CNT - 1)) begin
                                st                    <= ST_WAIT;
                                prot[i].precharge     <= 1'b1;
                                prot[i].soft_start_go <= 1'b1;
                                prot[i].shut_down     <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end

        // event counters; soft-start and shutdown hold them cleared
        always_ff @(posedge sys_clk) begin
            if (rst || !det || st == ST_DISCH || st == ST_OFF) begin
                hs_cnt <= '0;
                ls_cnt <= '0;
                clean  <= '0;
                ls_evt <= 1'b0;
            end else begin
                if (hit) begin
                    hs_cnt <= hs_cnt + 9'h001;
                end else if (cycle_tick && (st == ST_RUN || st == ST_LS_ON)) begin
                    hs_cnt <= '0;
                end
                if (ls_hit) begin
                    ls_cnt <= ls_cnt + 9'h001;
                end
                if (cycle_tick) begin
                    // an event in the tick cycle still counts against the clean run
                    ls_evt <= 1'b0;
                    if (ls_evt || ls_hit) begin
                        clean <= '0;
                    end else if (clean == CLEAN_LAST) begin
                        clean  <= '0;
                        ls_cnt <= '0;
                    end else begin
                        clean <= clean + 3'h1;
                    end
                end else if (ls_hit) begin
                    ls_evt <= 1'b1;
                end
            end
        end
    end
endmodule : opc_top

// File: test/opc_stage_model.sv
// power stage model: switching clock, pwm comparator and current sense
module opc_stage_model
    import opc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire opc_pkg::opc_gate_t gate [NSW],
    input  wire logic [1:0]        mode [NSW],
    output logic                   cycle_tick = 1'b0,
    output logic [NSW-1:0]         cur_over = '0,
    output logic [NSW-1:0]         pwm_end = '0
);
    logic [3:0] tcnt = 4'h0;
    logic [3:0] on_cnt [NSW] = '{default: 4'h0};
    logic [3:0] ls_cnt [NSW] = '{default: 4'h0};

    // free-running 16-cycle switching period
    always_ff @(posedge sys_clk) begin
        tcnt <= tcnt + 4'h1;
        cycle_tick <= (tcnt == 4'hf);
    end

    // mode 1 trips while the high side conducts, mode 2 briefly on the low side;
    // the low-side trip is a short pulse so the hold can end at a later tick
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NSW; i++) begin
            on_cnt[i] <= gate[i].hs_gate ? on_cnt[i] + 4'(on_cnt[i] != 4'hf) : 4'h0;
            ls_cnt[i] <= gate[i].ls_gate ? ls_cnt[i] + 4'(ls_cnt[i] != 4'hf) : 4'h0;
            pwm_end[i] <= (on_cnt[i] >= 4'h6);
            cur_over[i] <= (mode[i] == 2'h1 && gate[i].hs_gate)
                        || (mode[i] == 2'h2 && ls_cnt[i] >= 4'h1 && ls_cnt[i] <= 4'h3);
        end
    end
endmodule : opc_stage_model

// File: test/opc_top_props.sv
// port checker for the overcurrent protection control, switcher one and its pair
module opc_top_props
    import opc_pkg::*;
#(
    parameter int OFF_CNT   = 40,
    parameter int DISCH_CNT = 10
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic [1:0]         share_pair,
    input wire logic               digital_soft_start,
    input wire opc_pkg::opc_gate_t gate [NSW],
    input wire opc_pkg::opc_prot_t prot [NSW],
    input wire logic               load_done,
    input wire logic               store_busy
);
    int pull_len;
    int off_len;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    always_ff @(posedge sys_clk) begin
        pull_len <= (!rst && prot[0].comp_pull_low) ? pull_len + 1 : 0;
    end

    // off window is long, so count it instead of repeating
    always_ff @(posedge sys_clk) begin
        off_len <= (!rst && prot[0].shut_down) ? off_len + 1 : 0;
    end

    chk_no_overlap: assert property (!(gate[0].hs_gate && gate[0].ls_gate))
        else $error("both gates on together");
    chk_cut_ls_off: assert property ($fell(gate[0].hs_gate) && !gate[0].ls_gate |=> !gate[0].ls_gate [*8])
        else $error("low side on after a limit cut");
    chk_clamp_mode: assert property (prot[0].comp_clamp || prot[0].ea_tristate |->
        prot[0].ea_tristate == share_pair[0] && prot[0].comp_clamp != share_pair[0])
        else $error("clamp and tristate disagree with share mode");
    chk_shut_entry: assert property ($rose(prot[0].shut_down) |->
        prot[0].comp_pull_low && prot[0].ss_discharge && gate[0] == '0)
        else $error("shutdown without discharge");
    chk_ss_reset: assert property ($rose(prot[0].shut_down) |->
        prot[0].ss_value_reset == digital_soft_start ##1 !prot[0].ss_value_reset)
        else $error("soft-start value reset wrong");
    chk_disch_len: assert property ($fell(prot[0].comp_pull_low) |->
        pull_len == DISCH_CNT && !prot[0].ss_discharge)
        else $error("discharge length wrong");
    chk_off_len: assert property ($fell(prot[0].shut_down) |->
        off_len == OFF_CNT)
        else $error("off window length wrong");
    chk_restart_pulse: assert property ($rose(prot[0].soft_start_go) |->
        prot[0].precharge && !prot[0].comp_pull_low ##1 !prot[0].soft_start_go)
        else $error("restart pulse wrong");
    chk_pair_down: assert property (share_pair[0] && $rose(prot[0].shut_down || prot[1].shut_down) |->
        prot[0].shut_down && prot[1].shut_down)
        else $error("pair not shut down together");
    chk_store_len: assert property ($rose(store_busy) |-> store_busy [*4] ##1 !store_busy)
        else $error("store busy length wrong");
    chk_load_first: assert property (!load_done |-> gate[0] == '0 && gate[1] == '0)
        else $error("gates on before load");
endmodule : opc_top_props

// File: test/opc_top_tb.sv
// self-checking bench for the overcurrent protection control
module opc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import opc_pkg::*;

    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    logic             cycle_tick;
    logic [NSW-1:0]   cur_over;
    logic [NSW-1:0]   pwm_end;
    logic [NSW-1:0]   soft_start_active = '0;
    logic [1:0]       share_pair = '0;
    logic             digital_soft_start = 1'b1;
    opc_cfg_t         cfg = '0;
    logic             store_cmd = 1'b0;
    opc_gate_t        gate [NSW];
    opc_prot_t        prot [NSW];
    logic [LIM_W-1:0] peak_current_limit [NSW];
    logic             load_done;
    logic             store_busy;
    logic [1:0]       mode [NSW] = '{default: 2'h0};
    logic [LIM_W-1:0] exp_lim [NSW] = '{3'h4, 3'h4, 3'h3, 3'h3};
    logic             seen_shut = 1'b0;
    logic             seen_clamp = 1'b0;
    logic             seen_tri = 1'b0;
    int               err_total = 0;
    int               num_checks = 0;
    int               k;

    initial forever #5 sys_clk = ~sys_clk;

    // short off and discharge counts keep the run small
    opc_top #(.OFF_CNT(40), .DISCH_CNT(10)) uut (.sys_clk(sys_clk), .rst(rst), .cycle_tick(cycle_tick),
        .cur_over(cur_over), .pwm_end(pwm_end), .soft_start_active(soft_start_active), .share_pair(share_pair),
        .digital_soft_start(digital_soft_start), .cfg(cfg), .store_cmd(store_cmd), .gate(gate), .prot(prot),
        .peak_current_limit(peak_current_limit), .load_done(load_done), .store_busy(store_busy));
    opc_stage_model stage (.sys_clk(sys_clk), .gate(gate), .mode(mode), .cycle_tick(cycle_tick),
        .cur_over(cur_over), .pwm_end(pwm_end));

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask : check

    task automatic bound(input int n, input string msg);
        if (k >= n) begin
            check(1'b0, msg);
            wrap_up();
        end
    endtask : bound

    // sample just after the edge so registered outputs have settled
    task automatic tick1();
        @(posedge sys_clk);
        #1;
        seen_shut = seen_shut | (prot[0].shut_down === 1'b1);
        seen_clamp = seen_clamp | (prot[0].comp_clamp === 1'b1);
        seen_tri = seen_tri | (prot[0].ea_tristate === 1'b1);
    endtask : tick1

    task automatic clear_seen();
        seen_shut = 1'b0;
        seen_clamp = 1'b0;
        seen_tri = 1'b0;
    endtask : clear_seen

    task automatic do_reset();
        @(posedge sys_clk) rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (k = 0; k < 20 && load_done !== 1'b1; k++) tick1();
        bound(20, "load never finished");
    endtask : do_reset

    task automatic cfg_write(input int s, input int c);
        @(posedge sys_clk) cfg <= '{we: 1'b1, sel: 2'(s), code: 3'(c)};
        @(posedge sys_clk) cfg.we <= 1'b0;
        if (c <= (s < 2 ? 4 : 3)) exp_lim[s] = 3'(c);
        tick1();
        check(peak_current_limit[s] === exp_lim[s], "limit write result");
    endtask : cfg_write

    task automatic limits_match(input string msg);
        for (int i = 0; i < NSW; i++) check(peak_current_limit[i] === exp_lim[i], msg);
    endtask : limits_match

    task automatic wait_shut(input int sw, input int n);
        for (k = 0; k < n && prot[sw].shut_down !== 1'b1; k++) tick1();
        bound(n, "no shutdown");
    endtask : wait_shut

    task automatic wait_restart();
        for (k = 0; k < 100 && prot[0].shut_down === 1'b1; k++) tick1();
        bound(100, "no restart");
    endtask : wait_restart

    task automatic t_config();
        for (int s = 0; s < NSW; s++) for (int c = 0; c < 8; c++) cfg_write(s, c);
        $display("config codes done");
    endtask : t_config

    task automatic t_store();
        cfg_write(1, 1);
        cfg_write(3, 0);
        @(posedge sys_clk) store_cmd <= 1'b1;
        @(posedge sys_clk) store_cmd <= 1'b0;
        #1 check(store_busy === 1'b1, "store not started");
        for (k = 0; k < 8 && store_busy === 1'b1; k++) tick1();
        bound(8, "store never ends");
        cfg_write(1, 3);
        do_reset();
        exp_lim[1] = 3'h1;
        limits_match("stored limit not restored");
        $display("store and reload done");
    endtask : t_store

    task automatic t_hs_limit();
        clear_seen();
        @(posedge sys_clk) mode[0] <= 2'h1;
        for (k = 0; k < 40 && gate[0].hs_gate !== 1'b1; k++) tick1();
        bound(40, "high side never on");
        for (k = 0; k < 40 && gate[0].hs_gate === 1'b1; k++) tick1();
        check(k < 40 && gate[0].ls_gate === 1'b0, "no cut at limit");
        for (k = 0; k < 60 && gate[0].hs_gate !== 1'b1; k++) tick1();
        check(k > 16 && k < 60, "skipped cycle missing");
        wait_shut(0, 20000);
        check(seen_clamp === 1'b1 && seen_tri === 1'b0, "clamp not used alone");
        @(posedge sys_clk) mode[0] <= 2'h0;
        wait_restart();
        $display("high-side limit done");
    endtask : t_hs_limit

    task automatic t_pair();
        @(posedge sys_clk) share_pair <= 2'b01;
        digital_soft_start <= 1'b0;
        repeat (4) tick1();
        clear_seen();
        @(posedge sys_clk) mode[0] <= 2'h1;
        wait_shut(1, 20000);
        check(prot[0].shut_down === 1'b1, "pair not down together");
        check(seen_tri === 1'b1 && seen_clamp === 1'b0, "shared mode clamped");
        @(posedge sys_clk) mode[0] <= 2'h0;
        wait_restart();
        @(posedge sys_clk) share_pair <= 2'b00;
        digital_soft_start <= 1'b1;
        $display("shared pair done");
    endtask : t_pair

    task automatic t_ls();
        @(posedge sys_clk) mode[0] <= 2'h2;
        // synced over still high at the next tick, so each event spans two periods
        wait_shut(0, 600 * 16);
        check(k / 32 >= 250 && k / 32 <= 262, "low-side count wrong");
        @(posedge sys_clk) mode[0] <= 2'h0;
        wait_restart();
        $display("low-side limit done");
    endtask : t_ls

    // two runs that together pass the shutdown count, split by clean cycles
    task automatic t_clear(input logic [1:0] m, input int n);
        clear_seen();
        @(posedge sys_clk) mode[0] <= m;
        repeat (n * 16) tick1();
        @(posedge sys_clk) mode[0] <= 2'h0;
        repeat (8 * 16) tick1();
        @(posedge sys_clk) mode[0] <= m;
        repeat (n * 16) tick1();
        @(posedge sys_clk) mode[0] <= 2'h0;
        repeat (4 * 16) tick1();
        check(seen_shut === 1'b0, "counter not cleared");
        $display("counter clear done");
    endtask : t_clear

    task automatic t_soft();
        @(posedge sys_clk) soft_start_active[0] <= 1'b1;
        repeat (4) tick1();
        clear_seen();
        @(posedge sys_clk) mode[0] <= 2'h1;
        repeat (40 * 16) tick1();
        check(seen_clamp === 1'b0 && seen_shut === 1'b0, "limit acted in soft-start");
        @(posedge sys_clk) mode[0] <= 2'h0;
        soft_start_active[0] <= 1'b0;
        repeat (32) tick1();
        $display("soft-start blanking done");
    endtask : t_soft

    initial begin
        do_reset();
        limits_match("default limit wrong");
        t_config();
        t_store();
        t_hs_limit();
        t_pair();
        t_ls();
        t_clear(2'h1, 400);
        t_clear(2'h2, 400);
        t_soft();
        wrap_up();
    end
endmodule : opc_top_tb

bind opc_top opc_top_props #(.OFF_CNT(OFF_CNT), .DISCH_CNT(DISCH_CNT)) props (.sys_clk(sys_clk), .rst(rst),
    .share_pair(share_pair), .digital_soft_start(digital_soft_start), .gate(gate), .prot(prot),
    .load_done(load_done), .store_busy(store_busy));
